// [rtl/gain_loader_pkg.sv]
// shared constants and types for the serial gain word loader
package gain_loader_pkg;
  localparam int unsigned GAIN_BITS = 8;                 // bits in one gain word
  localparam logic [7:0] GAIN_RESET_CODE = 8'h00;        // code committed at power-up
  // gain in hundredths of a dB: code 0, step per binary weight and msb alone
  localparam int GAIN_BASE_CDB = -1816;                  // -18.16 dB at code zero
  localparam int GAIN_STEP_CDB = 602;                    // 6.02 dB per binary weight
  localparam int GAIN_MSB_CDB = 3000;                    // +30 dB with msb alone
  localparam int unsigned SYNC_STAGES = 2;               // flops ahead of any logic

  // serial pins travelling together, raw or synchronised
  typedef struct packed {
    logic clk_lvl;                                       // serial clock level
    logic data;                                          // serial data level
    logic load_n;                                        // load-enable level
  } serial_pins_t;

  // power and transmit state of the amplifier
  typedef struct packed {
    logic transmit;                                      // upstream path active
    logic between_burst;                                 // reduced-power idle
    logic sleeping;                                      // lowest-power sleep
  } power_state_t;
endpackage

// [rtl/pin_sync.sv]
// two-flop synchroniser for a group of asynchronous pins
module pin_sync
  import gain_loader_pkg::*;
#(
  parameter int unsigned WIDTH = 3,                      // pins in the group
  parameter logic [WIDTH-1:0] RESET_VAL = '1             // idle levels under reset
) (
  input wire logic ref_clk,                              // block clock
  input wire logic rst_n,                                // async reset, active low
  input wire logic [WIDTH-1:0] async_in,                 // raw pin levels
  output logic [WIDTH-1:0] sync_out                      // synchronised levels
);
  logic [WIDTH-1:0] meta_r;                              // first stage, read only by second

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs at least one pin");
  end

  // two stages; the first feeds nothing but the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// [rtl/serial_gain_word_loader.sv]
// serial gain word loader: shift register, commit latch and power modes
module serial_gain_word_loader
  import gain_loader_pkg::*;
#(
  parameter int unsigned WORD_BITS = GAIN_BITS           // gain word width
) (
  input wire logic ref_clk,                              // 10 MHz block clock
  input wire logic rst_n,                                // async reset, active low
  input wire logic serial_clk,                           // serial clock pin from controller
  input wire logic serial_gain_in,                       // serial data pin
  input wire logic load_enable_n,                        // load-enable pin, active low
  input wire logic transmit_on,                          // transmit enable pin
  input wire logic sleep_n,                              // sleep pin, active low
  output logic [WORD_BITS-1:0] gain_code,                // committed attenuator code
  output logic signed [15:0] gain_cdb,                   // committed gain in 0.01 dB
  output logic [3:0] bit_count,                          // bits shifted this window, saturates
  output logic word_valid,                               // last commit had at least eight bits
  output logic commit_pulse,                             // one-cycle pulse at each commit
  output power_state_t power_state                       // amplifier power state
);
  // elaboration check: shift, count and dB logic are built for eight-bit words only
  if (WORD_BITS != GAIN_BITS) begin : g_width_check
    $error("gain word must be eight bits");
  end

  serial_pins_t pins_raw;                                // raw pins grouped
  serial_pins_t pins_s;                                  // synchronised pins
  logic clk_prev_r;                                      // serial clock one cycle ago
  logic load_prev_r;                                     // load-enable one cycle ago
  logic [WORD_BITS-1:0] shift_r;                         // serial shift register
  logic [WORD_BITS-1:0] shift_nxt;                       // shift register next value
  logic [3:0] count_r;                                   // bits seen in this window
  logic [3:0] count_nxt;                                 // count next value
  logic [WORD_BITS-1:0] gain_r;                          // committed gain code
  logic valid_r;                                         // committed word was complete
  logic commit_r;                                        // registered commit pulse
  logic signed [15:0] cdb_r;                             // registered gain in 0.01 dB
  // dB step count of the committed code
  logic [WORD_BITS-1:0] weight_hit;                      // bit i set when code reaches weight i
  logic [3:0] step_count;                                // binary weights reached by the code

  assign pins_raw = '{clk_lvl: serial_clk, data: serial_gain_in, load_n: load_enable_n};

  // load-enable idles high so no window opens during reset
  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h1)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // edge detection on synchronised levels only; serial clock must be well under 5 MHz
  // each serial level must hold more than one ref_clk cycle or an edge is lost with no sign,
  // the price of sampling the link instead of clocking logic from it
  wire clk_rise = pins_s.clk_lvl & ~clk_prev_r;
  wire load_fall = ~pins_s.load_n & load_prev_r;
  wire load_rise = pins_s.load_n & ~load_prev_r;
  wire shift_en = clk_rise & ~pins_s.load_n;
  wire count_full = (count_r >= 4'(GAIN_BITS));

  // msb first: each new bit enters at the bottom and pushes older ones up
  assign shift_nxt = shift_en ? {shift_r[WORD_BITS-2:0], pins_s.data} : shift_r;
  // a clock rise in the window's first cycle still counts: the clear loads that bit as the first
  assign count_nxt = load_fall ? {3'h0, shift_en} :
                     (shift_en && !count_full) ? count_r + 4'h1 : count_r;

  // edge history
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_r <= 1'b0;
      load_prev_r <= 1'b1;
    end else begin
      clk_prev_r <= pins_s.clk_lvl;
      load_prev_r <= pins_s.load_n;
    end
  end

  // shift register and bit count
  // the register is not cleared at window start, so a short load keeps older low bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
      count_r <= 4'h0;
    end else begin
      shift_r <= shift_nxt;
      count_r <= count_nxt;
    end
  end

  // commit on load-enable rise; the gain is held otherwise
  // a short window still commits; word_valid tells the caller that it was short
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_r <= GAIN_RESET_CODE;
      valid_r <= 1'b0;
      commit_r <= 1'b0;
    end else begin
      commit_r <= load_rise;
      if (load_rise) begin
        gain_r <= shift_r;
        valid_r <= count_full;
      end
    end
  end

  // one 6.02 dB step per binary weight up to the highest set bit; lower set bits add
  // nothing, so codes with several bits take the step of their top bit (coarse model)
  // a thermometer of weights keeps the dB value out of a wide multiplier
  for (genvar i = 0; i < WORD_BITS; i++) begin : g_weight
    assign weight_hit[i] = |gain_r[WORD_BITS-1:i];
  end
  assign step_count = 4'($countones(weight_hit));

  // gain in hundredths of a dB, from the step count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cdb_r <= 16'(GAIN_BASE_CDB);
    end else begin
      cdb_r <= 16'(GAIN_BASE_CDB + GAIN_STEP_CDB * int'(step_count));
    end
  end

  // power pins act asynchronously on the analog path, so they bypass the flops
  // sleep wins over transmit so the two low-power states never overlap
  assign power_state.sleeping = ~sleep_n;
  assign power_state.transmit = transmit_on & sleep_n;
  assign power_state.between_burst = ~transmit_on & sleep_n;

  assign gain_code = gain_r;
  assign gain_cdb = cdb_r;
  assign bit_count = count_r;
  assign word_valid = valid_r;
  assign commit_pulse = commit_r;

  // checks: each property watches a rule that the logic above must keep
  // all share the block clock and are off while reset is held
  property p_commit_takes_shift;
    @(posedge ref_clk) disable iff (!rst_n) load_rise |=> (gain_r == $past(shift_r));
  endproperty
  a_commit_takes_shift: assert property (p_commit_takes_shift) else $error("commit missed shift word");

  property p_gain_held;
    @(posedge ref_clk) disable iff (!rst_n) !load_rise |=> $stable(gain_r);
  endproperty
  a_gain_held: assert property (p_gain_held) else $error("gain changed without commit");

  property p_no_shift_high;
    @(posedge ref_clk) disable iff (!rst_n) pins_s.load_n |=> $stable(shift_r);
  endproperty
  a_no_shift_high: assert property (p_no_shift_high) else $error("shift while load-enable high");

  property p_msb_first;
    @(posedge ref_clk) disable iff (!rst_n)
      shift_en |=> (shift_r[0] == $past(pins_s.data)) && (shift_r[7:1] == $past(shift_r[6:0]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bad shift order");

  property p_gain_map;
    @(posedge ref_clk) disable iff (!rst_n)
      $stable(gain_r) |=> (cdb_r == 16'(GAIN_BASE_CDB + GAIN_STEP_CDB * $clog2(int'($past(gain_r)) + 1)));
  endproperty
  a_gain_map: assert property (p_gain_map) else $error("gain dB mapping wrong");

  property p_msb_alone;
    @(posedge ref_clk) disable iff (!rst_n) (gain_r == 8'h80) ##1 (gain_r == 8'h80) |-> cdb_r == 16'(GAIN_MSB_CDB);
  endproperty
  a_msb_alone: assert property (p_msb_alone) else $error("msb gain not +30 dB");

  property p_count_eight;
    @(posedge ref_clk) disable iff (!rst_n) load_rise |=> (valid_r == ($past(count_r) >= 4'h8));
  endproperty
  a_count_eight: assert property (p_count_eight) else $error("word validity wrong");

  property p_power_excl;
    @(posedge ref_clk) disable iff (!rst_n)
      !sleep_n |-> power_state.sleeping && !power_state.transmit && !power_state.between_burst;
  endproperty
  a_power_excl: assert property (p_power_excl) else $error("sleep not dominant");

  property p_tx_follow;
    @(posedge ref_clk) disable iff (!rst_n) sleep_n |-> (power_state.transmit == transmit_on);
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("transmit state wrong");

  property p_fall_clears;
    @(posedge ref_clk) disable iff (!rst_n) load_fall |=> count_r == {3'h0, $past(shift_en)};
  endproperty
  a_fall_clears: assert property (p_fall_clears) else $error("count not cleared at window start");

  // commit pulse: raised by every commit and never longer than one cycle
  property p_pulse_on_commit;
    @(posedge ref_clk) disable iff (!rst_n) load_rise |=> commit_r;
  endproperty
  a_pulse_on_commit: assert property (p_pulse_on_commit) else $error("commit without pulse");

  property p_commit_single;
    @(posedge ref_clk) disable iff (!rst_n) commit_r |=> !commit_r;
  endproperty
  a_commit_single: assert property (p_commit_single) else $error("commit pulse too long");

  // the count saturates so a long window cannot wrap it
  property p_count_limit;
    @(posedge ref_clk) disable iff (!rst_n) count_r <= 4'(GAIN_BITS);
  endproperty
  a_count_limit: assert property (p_count_limit) else $error("bit count beyond word");

  property p_valid_held;
    @(posedge ref_clk) disable iff (!rst_n) !load_rise |=> $stable(valid_r);
  endproperty
  a_valid_held: assert property (p_valid_held) else $error("word validity changed without commit");
endmodule

// [dv/gain_ctrl_model.sv]
// controller model driving the three-wire gain port
module gain_ctrl_model (
  input wire logic ref_clk,         // block clock, paces the serial timing
  output logic serial_clk,          // serial clock, idles low between bit pulses
  output logic serial_gain_in,      // serial data, no pull on the line
  output logic load_enable_n        // load-enable, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serial_clk = 1'b0;
    serial_gain_in = 1'b0;
    load_enable_n = 1'b1;
  end
  // wait n block cycles, then step just off the edge
  task automatic pace(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // a frame opens on the falling edge of load-enable
  task automatic open_frame();
    pace(1);
    load_enable_n = 1'b0;
    pace(4);
  endtask
  // data set while the clock is low so it is settled at the rise; 800 ns period
  task automatic bit_out(input logic b);
    serial_gain_in = b;
    pace(4);
    serial_clk = 1'b1;
    pace(4);
    serial_clk = 1'b0;
  endtask
  // rise of load-enable commits; released data line shows the inverse, not the last bit
  task automatic close_frame();
    pace(4);
    load_enable_n = 1'b1;
    serial_gain_in = ~serial_gain_in;
  endtask
endmodule

// [dv/test_serial_gain_word_loader.sv]
// self-checking bench for the serial gain word loader
module test_serial_gain_word_loader;
  timeunit 1ns;
  timeprecision 1ns;
  import gain_loader_pkg::*;
  logic ref_clk, rst_n, serial_clk, serial_gain_in, load_enable_n, transmit_on, sleep_n; // stimulus
  logic [7:0] gain_code; // committed code
  logic signed [15:0] gain_cdb; // committed gain
  logic [3:0] bit_count; // bits in this window
  logic word_valid, commit_pulse; // commit status
  power_state_t power_state; // power mode
  int failures, n_tests, cycles; // counters
  serial_gain_word_loader DUT (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(serial_clk),
    .serial_gain_in(serial_gain_in), .load_enable_n(load_enable_n), .transmit_on(transmit_on),
    .sleep_n(sleep_n), .gain_code(gain_code), .gain_cdb(gain_cdb), .bit_count(bit_count),
    .word_valid(word_valid), .commit_pulse(commit_pulse), .power_state(power_state));
  gain_ctrl_model ctl (.ref_clk(ref_clk), .serial_clk(serial_clk), .serial_gain_in(serial_gain_in),
    .load_enable_n(load_enable_n));
  always #50 ref_clk = ~ref_clk;
  // compare and report; four-state so unknowns never match
  task automatic chk(input string what, input logic signed [31:0] seen, input logic signed [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard: a load takes under 90 cycles, so 3000 is ample
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic shift8(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) ctl.bit_out(w[i]);
  endtask
  task automatic load(input logic [7:0] w);
    ctl.open_frame();
    shift8(w);
    ctl.close_frame();
  endtask
  // bounded wait for the commit pulse, sampled mid-cycle
  task automatic wait_commit();
    for (int i = 0; i < 12 && commit_pulse !== 1'b1; i++) @(negedge ref_clk);
    chk("commit_pulse", commit_pulse, 1'b1);
    @(negedge ref_clk);
    chk("commit_pulse width", commit_pulse, 1'b0);
  endtask
  // msb first, then a window that must not disturb the gain until it closes
  task automatic s_load_and_hold();
    load(8'ha5);
    wait_commit();
    chk("gain_code", gain_code, 8'ha5);
    chk("word_valid", word_valid, 1'b1);
    ctl.open_frame();
    for (int i = 7; i >= 0; i--) begin
      if (i == 3) chk("gain_code held", gain_code, 8'ha5);
      ctl.bit_out(~i[0]);
    end
    ctl.close_frame();
    wait_commit();
    chk("gain_code", gain_code, 8'h55);
  endtask
  // stray clocks with load high are ignored; a short load then keeps older bits
  task automatic s_stray_short();
    repeat (3) ctl.bit_out(1'b1);
    chk("gain_code idle", gain_code, 8'h55);
    ctl.open_frame();
    repeat (4) ctl.bit_out(1'b0);
    ctl.close_frame();
    wait_commit();
    chk("gain_code short", gain_code, 8'h50);
    chk("word_valid short", word_valid, 1'b0);
    repeat (3) ctl.bit_out(1'b1);
    chk("bit_count idle", bit_count, 4'h4);
  endtask
  // ten clocks in one window keep the last eight
  task automatic s_extra();
    ctl.open_frame();
    repeat (2) ctl.bit_out(1'b1);
    shift8(8'h3c);
    ctl.close_frame();
    wait_commit();
    chk("gain_code long", gain_code, 8'h3c);
    chk("bit_count long", bit_count, 4'h8);
  endtask
  // every single-weight code of the gain table plus code zero
  task automatic s_gain_table();
    logic [7:0] w;
    for (int k = -1; k < 8; k++) begin
      w = (k < 0) ? 8'h00 : 8'h01 << k;
      load(w);
      wait_commit();
      @(negedge ref_clk);
      chk("gain_code", gain_code, w);
      chk("gain_cdb", gain_cdb, GAIN_BASE_CDB + GAIN_STEP_CDB * (k + 1));
    end
  endtask
  // pins act without waiting for a clock edge; sleep dominates
  task automatic s_power();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      #1;
      transmit_on = i[0];
      sleep_n = i[1];
      #5;
      chk("power_state", power_state, !i[1] ? 3'b001 : (i[0] ? 3'b100 : 3'b010));
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    transmit_on = 1'b0;
    sleep_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    @(negedge ref_clk);
    chk("gain_code reset", gain_code, GAIN_RESET_CODE);
    chk("gain_cdb reset", gain_cdb, GAIN_BASE_CDB);
    s_load_and_hold();
    s_stray_short();
    s_extra();
    s_gain_table();
    s_power();
    end_of_test();
  end
endmodule
